// ### core/lse_pkg.sv
// Constants and types for the line status, eoc and loopback register bank.
// Assumes a single 125 MHz clock and an AXI4-Lite master with 32-bit data.
package lse_pkg;

    // ------------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int IDX_W = 6;

    // ------------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [IDX_W-1:0] IDX_LINE_STATUS = 6'h07;
    localparam logic [IDX_W-1:0] IDX_SPARE_BITS = 6'h08;
    localparam logic [IDX_W-1:0] IDX_EOC_CTRL = 6'h09;
    localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 6'h10;
    localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 6'h11;
    localparam logic [IDX_W-1:0] IDX_GENERAL_CTRL = 6'h12;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int EOC_ADDR_LSB = 0;
    localparam int EOC_ADDR_W = 3;
    localparam int MSG_FLAG_BIT = 3;
    localparam int B1_LOOP_BIT = 4;
    localparam int B2_LOOP_BIT = 5;
    localparam int TRANSP_LOOP_BIT = 6;
    localparam int CRC_CORRUPT_BIT = 7;
    localparam int AUTO_OPS_BIT = 4;
    localparam int IRQ_ACT_BIT = 1;
    localparam int IRQ_BLK_BIT = 2;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] EOC_CTRL_RST = 8'hf8;
    localparam logic [7:0] LINE_STATUS_RST = 8'h00;
    localparam logic [6:0] SPARE_BITS_RST = 7'h00;
    localparam logic [7:0] GENERAL_CTRL_RST = 8'h00;
    localparam logic [7:0] IRQ_MASK_RST = 8'h00;
    localparam logic [7:0] IRQ_WMASK = 8'h06;

    // AXI response codes
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // ------------------------------------------------------------------
    // Datapath widths
    // ------------------------------------------------------------------
    localparam int BCH_W = 8;
    localparam int BBD_W = 18;
    localparam int CRC_W = 12;

    // Overhead bits decoded from one received U frame
    typedef struct packed {
        logic info4;
        logic aib;
        logic febe;
        logic nebe;
        logic uoa;
        logic frame_lost_n;
        logic transceiver_up_flag;
        logic far_ready_flag;
        logic [6:0] spare;
    } lse_rx_ovh_t;

    // Manual or automatic eoc transmit fields
    typedef struct packed {
        logic [EOC_ADDR_W-1:0] addr;
        logic tx_ops_msg_flag;
    } lse_eoc_tx_t;

endpackage

// ### core/lse_regs.sv
// Line status, spare bit mirror, eoc transmit control and loopback bank.
// Assumes strobed decoded overhead and one AXI4-Lite transfer each way.
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module lse_regs
(
    input  wire logic ref_clk_i,                       // 125 MHz clock
    input  wire logic arst_n_i,                        // Async reset, low
    // AXI4-Lite slave
    input  wire logic [lse_pkg::ADDR_W-1:0] awaddr_i,  // Write address
    input  wire logic awvalid_i,                       // Write addr valid
    output logic awready_o,                            // Write addr ready
    input  wire logic [lse_pkg::DATA_W-1:0] wdata_i,   // Write data
    input  wire logic [3:0] wstrb_i,                   // Byte enables
    input  wire logic wvalid_i,                        // Write data valid
    output logic wready_o,                             // Write data ready
    output logic [1:0] bresp_o,                        // Write response
    output logic bvalid_o,                             // Response valid
    input  wire logic bready_i,                        // Response ready
    input  wire logic [lse_pkg::ADDR_W-1:0] araddr_i,  // Read address
    input  wire logic arvalid_i,                       // Read addr valid
    output logic arready_o,                            // Read addr ready
    output logic [lse_pkg::DATA_W-1:0] rdata_o,        // Read data
    output logic [1:0] rresp_o,                        // Read response
    output logic rvalid_o,                             // Read data valid
    input  wire logic rready_i,                        // Read data ready
    // Received overhead
    input  wire logic rx_ovh_valid_i,                  // Frame decoded
    input  wire lse_pkg::lse_rx_ovh_t rx_ovh_i,        // Decoded bits
    // eoc transmit
    input  wire lse_pkg::lse_eoc_tx_t auto_eoc_i,      // Auto engine fields
    output lse_pkg::lse_eoc_tx_t tx_eoc_o,             // Fields to send
    // U bearer channels
    input  wire logic [lse_pkg::BCH_W-1:0] u_rx_b1_i,  // Received B1
    input  wire logic [lse_pkg::BCH_W-1:0] u_rx_b2_i,  // Received B2
    input  wire logic [lse_pkg::BCH_W-1:0] mtx_b1_i,   // Matrix B1 to U
    input  wire logic [lse_pkg::BCH_W-1:0] mtx_b2_i,   // Matrix B2 to U
    output logic [lse_pkg::BCH_W-1:0] u_tx_b1_o,       // Transmit B1
    output logic [lse_pkg::BCH_W-1:0] u_tx_b2_o,       // Transmit B2
    // S/T 2B+D words
    input  wire logic [lse_pkg::BBD_W-1:0] st_tx_i,    // S/T transmit word
    input  wire logic [lse_pkg::BBD_W-1:0] te_rx_i,    // Word from terminal
    output logic [lse_pkg::BBD_W-1:0] st_rx_o,         // S/T receive word
    // CRC
    input  wire logic [lse_pkg::CRC_W-1:0] crc_i,      // Computed CRC
    output logic [lse_pkg::CRC_W-1:0] crc_o,           // CRC to transmit
    // Interrupt
    output logic irq_o                                 // Level, high active
);
    import lse_pkg::*;

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    logic [7:0] line_overhead_status;
    logic [6:0] received_spare_bits;
    logic [7:0] eoc_tx_loopback_ctrl;
    logic [7:0] general_ctrl;
    logic [7:0] irq_status;
    logic [7:0] irq_mask;

    // Bus side state
    logic aw_got;
    logic w_got;
    logic [IDX_W-1:0] aw_idx;
    logic [DATA_W-1:0] w_data;
    logic [3:0] w_strb;

    // Derived controls
    logic do_write, wr_low, ar_take;
    logic [IDX_W-1:0] ar_idx;
    logic [7:0] ctrl_eff;
    logic auto_ops_channel;
    logic first_bearer_loop_n;
    logic second_bearer_loop_n;
    logic transparent_loop_n;
    logic check_corrupt_n;
    logic activation_change_irq, block_fault_irq;
    logic [7:0] irq_set;
    logic [7:0] irq_clr;
    logic [7:0] next_irq_status;
    logic [DATA_W-1:0] next_rdata;
    logic [1:0] next_rresp;

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    // A write fires once both halves are held, no response pending
    assign do_write = aw_got && w_got && !bvalid_o;
    assign wr_low = do_write && w_strb[0];
    assign ar_take = arvalid_i && arready_o;
    assign ar_idx = araddr_i[IDX_W+1:2];

    // Write address channel: one outstanding write at a time
    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            aw_got <= 1'b0;
            aw_idx <= '0;
            awready_o <= 1'b0;
        end
        else if (awvalid_i && awready_o)
        begin
            aw_got <= 1'b1;
            aw_idx <= awaddr_i[IDX_W+1:2];
            awready_o <= 1'b0;
        end
        else if (do_write)
            aw_got <= 1'b0;
        else if (!aw_got && !bvalid_o)
            awready_o <= 1'b1;
    end

    // Write data, taken apart from the address
    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            w_got <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
            wready_o <= 1'b0;
        end
        else if (wvalid_i && wready_o)
        begin
            w_got <= 1'b1;
            w_data <= wdata_i;
            w_strb <= wstrb_i;
            wready_o <= 1'b0;
        end
        else if (do_write)
            w_got <= 1'b0;
        else if (!w_got && !bvalid_o)
            wready_o <= 1'b1;
    end

    // Write response; unmapped or read-only targets answer with an error
    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            bvalid_o <= 1'b0;
            bresp_o <= RESP_OKAY;
        end
        else if (do_write)
        begin
            bvalid_o <= 1'b1;
            unique case (aw_idx)
                IDX_EOC_CTRL, IDX_IRQ_STATUS, IDX_IRQ_MASK,
                IDX_GENERAL_CTRL: bresp_o <= RESP_OKAY;
                default: bresp_o <= RESP_SLVERR;
            endcase
        end
        else if (bvalid_o && bready_i)
            bvalid_o <= 1'b0;
    end

    // ------------------------------------------------------------------
    // Software writable registers
    // ------------------------------------------------------------------
    // Software registers; eoc control keeps its value in auto mode
    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            eoc_tx_loopback_ctrl <= EOC_CTRL_RST;
            general_ctrl <= GENERAL_CTRL_RST;
            irq_mask <= IRQ_MASK_RST;
        end
        else if (wr_low)
        begin
            if (aw_idx == IDX_EOC_CTRL)
                eoc_tx_loopback_ctrl <= w_data[7:0];
            if (aw_idx == IDX_GENERAL_CTRL)
                general_ctrl <= w_data[7:0];
            if (aw_idx == IDX_IRQ_MASK)
                irq_mask <= w_data[7:0] & IRQ_WMASK;
        end
    end

    // ------------------------------------------------------------------
    // Received overhead mirrors
    // ------------------------------------------------------------------
    // strobe-only update
    // Reads never touch these; only a decoded frame loads them
    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            line_overhead_status <= LINE_STATUS_RST;
        else if (rx_ovh_valid_i)
            line_overhead_status <= {rx_ovh_i.info4, rx_ovh_i.aib,
                rx_ovh_i.febe, rx_ovh_i.nebe, rx_ovh_i.uoa,
                rx_ovh_i.frame_lost_n, rx_ovh_i.transceiver_up_flag,
                rx_ovh_i.far_ready_flag};
    end

    // spare bit mirror
    // Spare field order: 6..3 rows six to three, 2 row two, 1..0 row one
    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            received_spare_bits <= SPARE_BITS_RST;
        else if (rx_ovh_valid_i)
            received_spare_bits <= rx_ovh_i.spare;
    end

    // ------------------------------------------------------------------
    // Interrupt flags
    // ------------------------------------------------------------------
    // activation change detect
    assign activation_change_irq = rx_ovh_valid_i &&
        ((rx_ovh_i.far_ready_flag != line_overhead_status[0]) ||
         (rx_ovh_i.transceiver_up_flag != line_overhead_status[1]));
    assign block_fault_irq = rx_ovh_valid_i &&
        (!rx_ovh_i.nebe || !rx_ovh_i.febe);

    // Clear by reading the flags or by writing ones; a set in the same
    // cycle wins so that no event is dropped
    always_comb
    begin
        irq_set = 8'h00;
        irq_set[IRQ_ACT_BIT] = activation_change_irq;
        irq_set[IRQ_BLK_BIT] = block_fault_irq;
        irq_clr = 8'h00;
        if (ar_take && ar_idx == IDX_IRQ_STATUS)
            irq_clr = 8'hff;
        if (wr_low && aw_idx == IDX_IRQ_STATUS)
            irq_clr = irq_clr | w_data[7:0];
        next_irq_status = ((irq_status & ~irq_clr) | irq_set) & IRQ_WMASK;
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            irq_status <= 8'h00;
        else
            irq_status <= next_irq_status;
    end

    // Level output, one cycle behind the flags
    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            irq_o <= 1'b0;
        else
            irq_o <= |(irq_status & irq_mask);
    end

    // ------------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------------
    // Flags are captured before their clear so the reader sees the event
    always_comb
    begin
        next_rdata = '0;
        next_rresp = RESP_OKAY;
        unique case (ar_idx)
            IDX_LINE_STATUS: next_rdata[7:0] = line_overhead_status;
            IDX_SPARE_BITS: next_rdata[6:0] = received_spare_bits;
            IDX_EOC_CTRL: next_rdata[7:0] = eoc_tx_loopback_ctrl;
            IDX_IRQ_STATUS: next_rdata[7:0] = irq_status;
            IDX_IRQ_MASK: next_rdata[7:0] = irq_mask;
            IDX_GENERAL_CTRL: next_rdata[7:0] = general_ctrl;
            default: next_rresp = RESP_SLVERR;
        endcase
    end

    // One read at a time; data is valid one cycle after the address
    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            arready_o <= 1'b0;
            rvalid_o <= 1'b0;
            rdata_o <= '0;
            rresp_o <= RESP_OKAY;
        end
        else if (ar_take)
        begin
            arready_o <= 1'b0;
            rvalid_o <= 1'b1;
            rdata_o <= next_rdata;
            rresp_o <= next_rresp;
        end
        else if (rvalid_o && rready_i)
            rvalid_o <= 1'b0;
        else if (!rvalid_o)
            arready_o <= 1'b1;
    end

    // ------------------------------------------------------------------
    // Effective controls
    // ------------------------------------------------------------------
    assign auto_ops_channel = general_ctrl[AUTO_OPS_BIT];
    // ignored in auto mode
    // Auto mode falls back to the reset value: no loops, good CRC
    assign ctrl_eff = auto_ops_channel ? EOC_CTRL_RST : eoc_tx_loopback_ctrl;
    assign first_bearer_loop_n = ctrl_eff[B1_LOOP_BIT];
    assign second_bearer_loop_n = ctrl_eff[B2_LOOP_BIT];
    assign transparent_loop_n = ctrl_eff[TRANSP_LOOP_BIT];
    assign check_corrupt_n = ctrl_eff[CRC_CORRUPT_BIT];

    // manual eoc fields
    // The automatic engine owns the fields while it is enabled
    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            tx_eoc_o.addr <= EOC_CTRL_RST[EOC_ADDR_LSB +: EOC_ADDR_W];
            tx_eoc_o.tx_ops_msg_flag <= EOC_CTRL_RST[MSG_FLAG_BIT];
        end
        else if (auto_ops_channel)
            tx_eoc_o <= auto_eoc_i;
        else
        begin
            tx_eoc_o.addr <=
                eoc_tx_loopback_ctrl[EOC_ADDR_LSB +: EOC_ADDR_W];
            tx_eoc_o.tx_ops_msg_flag <= eoc_tx_loopback_ctrl[MSG_FLAG_BIT];
        end
    end

    // ------------------------------------------------------------------
    // Loopbacks and CRC
    // ------------------------------------------------------------------
    // Bearers switch alone, ahead of the matrix; the pin loop drops
    // terminal words; inverting all CRC bits forces a far-end mismatch
    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            u_tx_b1_o <= '0;
            u_tx_b2_o <= '0;
            st_rx_o <= '0;
            crc_o <= '0;
        end
        else
        begin
            u_tx_b1_o <= first_bearer_loop_n ? mtx_b1_i : u_rx_b1_i;
            u_tx_b2_o <= second_bearer_loop_n ? mtx_b2_i : u_rx_b2_i;
            st_rx_o <= transparent_loop_n ? te_rx_i : st_tx_i;
            crc_o <= check_corrupt_n ? crc_i : ~crc_i;
        end
    end

endmodule

// ### testbench/lse_regs_monitor.sv
// Checker for the line status, eoc and loopback register bank.
// Sees only the bank's ports; bound onto every lse_regs instance.
`timescale 1ns/100ps
module lse_regs_monitor
(
    input wire logic ref_clk_i, // Clock
    input wire logic arst_n_i, // Async reset
    input wire logic [lse_pkg::ADDR_W-1:0] awaddr_i, // Write address
    input wire logic awvalid_i, // Write addr valid
    input wire logic awready_o, // Write addr ready
    input wire logic [1:0] bresp_o, // Write response
    input wire logic bvalid_o, // Response valid
    input wire logic [lse_pkg::ADDR_W-1:0] araddr_i, // Read address
    input wire logic arvalid_i, // Read addr valid
    input wire logic arready_o, // Read addr ready
    input wire logic [lse_pkg::DATA_W-1:0] rdata_o, // Read data
    input wire logic [1:0] rresp_o, // Read response
    input wire logic rvalid_o, // Read valid
    input wire logic rready_i, // Read ready
    input wire logic rx_ovh_valid_i, // Frame strobe
    input wire lse_pkg::lse_rx_ovh_t rx_ovh_i, // Frame bits
    input wire logic [lse_pkg::BCH_W-1:0] u_rx_b1_i, // Received B1
    input wire logic [lse_pkg::BCH_W-1:0] mtx_b1_i, // Matrix B1
    input wire logic [lse_pkg::BCH_W-1:0] u_tx_b1_o, // Sent B1
    input wire logic [lse_pkg::BBD_W-1:0] st_tx_i, // S/T transmit
    input wire logic [lse_pkg::BBD_W-1:0] te_rx_i, // From terminal
    input wire logic [lse_pkg::BBD_W-1:0] st_rx_o, // S/T receive
    input wire logic [lse_pkg::CRC_W-1:0] crc_i, // Computed CRC
    input wire logic [lse_pkg::CRC_W-1:0] crc_o // Sent CRC
);
    import lse_pkg::*;
    logic [7:0] stat_q;
    logic [6:0] spare_q;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!arst_n_i);
    // Shadow of the last decoded frame, so reads can be judged
    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            stat_q <= 8'h00;
            spare_q <= 7'h00;
        end
        else if (rx_ovh_valid_i)
        begin
            stat_q <= rx_ovh_i[14:7];
            spare_q <= rx_ovh_i.spare;
        end
    end
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    chk_read_next: assert property (
        arvalid_i && arready_o |=> rvalid_o)
        else $error("read answer not one cycle after address");
    chk_read_hold: assert property (
        rvalid_o && !rready_i |=> rvalid_o && $stable(rdata_o))
        else $error("read data dropped before ready");
    chk_status_read: assert property (
        arvalid_i && arready_o && araddr_i == 8'h1c && !rx_ovh_valid_i
        |=> rdata_o[7:0] == stat_q)
        else $error("line status differs from last frame");
    chk_spare_read: assert property (
        arvalid_i && arready_o && araddr_i == 8'h20 && !rx_ovh_valid_i
        |=> rdata_o[7:0] == {1'b0, spare_q})
        else $error("spare bits differ from last frame");
    chk_bad_read: assert property (
        arvalid_i && arready_o && araddr_i == 8'h30
        |=> rresp_o == RESP_SLVERR && rdata_o == 32'h00000000)
        else $error("unmapped read not refused");
    chk_ro_write: assert property (
        awvalid_i && awready_o && (awaddr_i == 8'h1c || awaddr_i == 8'h20)
        |-> ##[1:8] (bvalid_o && bresp_o == RESP_SLVERR))
        else $error("write to read-only status accepted");
    chk_b1_select: assert property (
        1'b1 |=> u_tx_b1_o == $past(mtx_b1_i) || u_tx_b1_o == $past(u_rx_b1_i))
        else $error("B1 transmit from unknown source");
    chk_st_select: assert property (
        1'b1 |=> st_rx_o == $past(te_rx_i) || st_rx_o == $past(st_tx_i))
        else $error("S/T receive from unknown source");
    chk_crc_select: assert property (
        1'b1 |=> crc_o == $past(crc_i) || crc_o == ~$past(crc_i))
        else $error("transmitted CRC neither good nor inverted");
    cover property (rvalid_o && !rready_i);
    cover property (bvalid_o && bresp_o == RESP_SLVERR);
    cover property (rx_ovh_valid_i ##[1:8] (arvalid_i && araddr_i == 8'h1c));
endmodule

bind lse_regs lse_regs_monitor u_mon (.ref_clk_i, .arst_n_i, .awaddr_i,
    .awvalid_i, .awready_o, .bresp_o, .bvalid_o, .araddr_i, .arvalid_i,
    .arready_o, .rdata_o, .rresp_o, .rvalid_o, .rready_i, .rx_ovh_i,
    .rx_ovh_valid_i, .u_rx_b1_i, .mtx_b1_i, .u_tx_b1_o, .st_tx_i,
    .te_rx_i, .st_rx_o, .crc_i, .crc_o);

// ### testbench/lse_lt_model.sv
// Line termination model: decoded overhead frames and live B words.
// Assumes send_i is a one-cycle request from the bench.
`timescale 1ns/100ps
module lse_lt_model
(
    input wire logic clk_i, // Clock
    input wire logic rst_n_i, // Async reset, low
    input wire logic send_i, // Frame request
    input wire lse_pkg::lse_rx_ovh_t ovh_i, // Frame content
    output logic valid_o, // Frame strobe
    output lse_pkg::lse_rx_ovh_t ovh_o, // Decoded bits
    output logic [lse_pkg::BCH_W-1:0] b1_o, // Received B1
    output logic [lse_pkg::BCH_W-1:0] b2_o // Received B2
);
    import lse_pkg::*;
    // Frame bits invert outside the strobe so a stale capture shows up
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            valid_o <= 1'b0;
            ovh_o <= '0;
            b1_o <= 8'h00;
            b2_o <= 8'h11;
        end
        else
        begin
            valid_o <= send_i;
            ovh_o <= send_i ? ovh_i : ~ovh_o;
            b1_o <= b1_o + 8'h35;
            b2_o <= b2_o + 8'h5b;
        end
    end
endmodule

// ### testbench/test_lse_regs.sv
// Self-checking bench for the line status, eoc and loopback bank.
// Assumes the line termination model feeds the received side.
`timescale 1ns/100ps
module test_lse_regs;
    import lse_pkg::*;
    logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready, send, au;
    logic awready, wready, bvalid, arready, rvalid, irq, rx_valid, dp_due;
    logic [7:0] awaddr, araddr, mtx_b1, mtx_b2, u_rx_b1, u_rx_b2, tx_b1;
    logic [7:0] tx_b2, ctl, st, fl, mk;
    logic [6:0] sp;
    logic [31:0] wdata, rdata, r;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [17:0] st_tx, te_rx, st_rx;
    logic [11:0] crc_in, crc_out;
    lse_rx_ovh_t ovh, rx_ovh;
    lse_eoc_tx_t auto_eoc, tx_eoc;
    logic [49:0] dp_q[$];
    logic [33:0] rd_q[$];
    logic [1:0] wr_q[$];
    logic [7:0] tab[6] = '{8'hef, 8'hdf, 8'hbf, 8'h7f, 8'h07, 8'hf8};
    int miscompares = 0;
    int cmp_count = 0;
    lse_regs u_dut (.ref_clk_i(clk), .arst_n_i(rst_n), .awaddr_i(awaddr),
        .awvalid_i(awvalid), .awready_o(awready), .wdata_i(wdata),
        .wstrb_i(wstrb), .wvalid_i(wvalid), .wready_o(wready),
        .bresp_o(bresp), .bvalid_o(bvalid), .bready_i(bready),
        .araddr_i(araddr), .arvalid_i(arvalid), .arready_o(arready),
        .rdata_o(rdata), .rresp_o(rresp), .rvalid_o(rvalid),
        .rready_i(rready), .rx_ovh_valid_i(rx_valid), .rx_ovh_i(rx_ovh),
        .auto_eoc_i(auto_eoc), .tx_eoc_o(tx_eoc), .u_rx_b1_i(u_rx_b1),
        .u_rx_b2_i(u_rx_b2), .mtx_b1_i(mtx_b1), .mtx_b2_i(mtx_b2),
        .u_tx_b1_o(tx_b1), .u_tx_b2_o(tx_b2), .st_tx_i(st_tx),
        .te_rx_i(te_rx), .st_rx_o(st_rx), .crc_i(crc_in), .crc_o(crc_out),
        .irq_o(irq));
    lse_lt_model u_lt (.clk_i(clk), .rst_n_i(rst_n), .send_i(send),
        .ovh_i(ovh), .valid_o(rx_valid), .ovh_o(rx_ovh), .b1_o(u_rx_b1),
        .b2_o(u_rx_b2));
    // Free-running 125 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic cmp(input logic [49:0] got, input logic [49:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Scoreboard: oldest note per result
    always @(posedge clk)
    begin
        if (rvalid && rready && rd_q.size() > 0)
            cmp({rresp, rdata}, rd_q.pop_front());
        if (bvalid && bready && wr_q.size() > 0)
            cmp(bresp, wr_q.pop_front());
        if (dp_due && dp_q.size() > 0)
            cmp({tx_b1, tx_b2, st_rx, crc_out, tx_eoc}, dp_q.pop_front());
    end
    // ------------------------------------------------------------------
    // Bus and line tasks
    // ------------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, input logic [1:0] e);
        @(posedge clk);
        wr_q.push_back(e);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever
        begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
    endtask
    // Random ready stall
    task automatic rd(input logic [7:0] a, input logic [7:0] v,
                      input logic [1:0] e);
        int w;
        @(posedge clk);
        w = $urandom_range(2, 0);
        rd_q.push_back({e, 24'h000000, v});
        araddr <= a;
        arvalid <= 1'b1;
        rready <= (w == 0);
        forever
        begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
            if (rvalid && rready) break;
            if (w > 0) w--;
            rready <= (w == 0);
        end
        rready <= 1'b0;
    endtask
    task automatic frame(input lse_rx_ovh_t o);
        if (o.far_ready_flag !== st[0] || o.transceiver_up_flag !== st[1])
            fl[IRQ_ACT_BIT] = 1'b1;
        if (!o.nebe || !o.febe)
            fl[IRQ_BLK_BIT] = 1'b1;
        st = o[14:7];
        sp = o.spare;
        ovh <= o;
        send <= 1'b1;
        @(posedge clk);
        send <= 1'b0;
        repeat (4) @(posedge clk);
        cmp(irq, |(fl & mk));
    endtask
    // Noted at capture, judged one edge later
    task automatic dp();
        logic [7:0] m;
        lse_eoc_tx_t eo;
        r = $urandom;
        {mtx_b1, mtx_b2, crc_in} <= r[27:0];
        {st_tx, te_rx, auto_eoc} <= {r, 8'h5a};
        @(posedge clk);
        m = au ? 8'hf8 : ctl;
        eo = au ? auto_eoc : {m[2:0], m[MSG_FLAG_BIT]};
        dp_q.push_back({m[B1_LOOP_BIT] ? mtx_b1 : u_rx_b1,
            m[B2_LOOP_BIT] ? mtx_b2 : u_rx_b2, m[TRANSP_LOOP_BIT] ? te_rx :
            st_tx, m[CRC_CORRUPT_BIT] ? crc_in : ~crc_in, eo});
        dp_due <= 1'b1;
        @(posedge clk);
        dp_due <= 1'b0;
    endtask
    task automatic summarize();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Watchdog, well past the run's length
    initial
    begin
        #100us;
        miscompares++;
        summarize();
    end
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        {rst_n, awvalid, wvalid, bready, arvalid, rready, send} = '0;
        {awaddr, araddr, wdata, mtx_b1, mtx_b2, st_tx, te_rx, crc_in} = '0;
        {ovh, auto_eoc, au, dp_due, st, fl, mk, sp} = '0;
        wstrb = 4'hf;
        ctl = 8'hf8;
        void'($urandom(50605));
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        rd(8'h24, 8'hf8, RESP_OKAY);
        rd(8'h30, 8'h00, RESP_SLVERR);
        dp();
        repeat (5)
        begin
            r = $urandom;
            frame(r[14:0]);
            rd(8'h1c, st, RESP_OKAY);
            rd(8'h1c, st, RESP_OKAY);
            rd(8'h20, {1'b0, sp}, RESP_OKAY);
        end
        wr(8'h1c, 32'h000000ff, 4'hf, RESP_SLVERR);
        wr(8'h20, 32'h0000007f, 4'hf, RESP_SLVERR);
        rd(8'h1c, st, RESP_OKAY);
        wr(8'h44, 32'h00000006, 4'hf, RESP_OKAY);
        mk = 8'h06;
        rd(8'h40, fl, RESP_OKAY);
        fl = 8'h00;
        frame({~st, 7'h2a});
        frame({8'hef, 7'h55});
        wr(8'h40, 32'h00000006, 4'hf, RESP_OKAY);
        fl = 8'h00;
        repeat (2) @(posedge clk);
        cmp(irq, 1'b0);
        for (int i = 0; i < 9; i++)
        begin
            r = $urandom;
            ctl = (i < 6) ? tab[i] : r[7:0];
            wr(8'h24, {24'h000000, ctl}, 4'hf, RESP_OKAY);
            rd(8'h24, ctl, RESP_OKAY);
            dp();
        end
        wr(8'h48, 32'h00000010, 4'hf, RESP_OKAY);
        au = 1'b1;
        dp();
        wr(8'h48, 32'h00000000, 4'hf, RESP_OKAY);
        au = 1'b0;
        dp();
        wr(8'h24, 32'h00000000, 4'he, RESP_OKAY);
        rd(8'h24, ctl, RESP_OKAY);
        summarize();
    end
endmodule
